// ==== core/tspwm_pkg.sv ====
// Constants for the five-channel sync/PWM timer.
// Assumes one 25 MHz system clock and plain-port configuration.
package tspwm_pkg;
  localparam int NCH = 5;
  localparam int CW  = 16;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam logic [CW-1:0] GR_RST  = 16'hffff;
  // Counter clear select encoding
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  // Count clock select encoding
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV2 = 3'h1;
  localparam logic [2:0] CKS_DIV4 = 3'h2;
  localparam logic [2:0] CKS_DIV8 = 3'h3;
  localparam logic [2:0] CKS_EXT  = 3'h4;
  // Pin B I/O select encoding
  localparam logic [1:0] IOB_NONE = 2'h0;
  localparam logic [1:0] IOB_LO   = 2'h1;
  localparam logic [1:0] IOB_HI   = 2'h2;
  localparam logic [1:0] IOB_TOG  = 2'h3;
  // Combined mode select encoding
  localparam logic [1:0] CMD_RSPWM = 2'h3;
  localparam int PRE_W = 3;
  localparam logic [PRE_W-1:0] PRE_RST = 3'h0;
endpackage

// ==== core/tspwm_tick_if.sv ====
// Count-tick bundle between the prescaler and the channel core.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface tspwm_tick_if;
  logic [tspwm_pkg::NCH-1:0] tick;
  modport src  (output tick);
  modport sink (input  tick);
endinterface

// ==== core/tspwm_prescale.sv ====
// Per-channel count clock generation: divided system clock or ext edge.
// Assumes ext clock pins are asynchronous and sampled here.
`timescale 1ns/1ns
module tspwm_prescale (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [3*tspwm_pkg::NCH-1:0] cks,
  input  wire logic [2*tspwm_pkg::NCH-1:0] edge_sel,
  input  wire logic [tspwm_pkg::NCH-1:0]   ext_clk,
  tspwm_tick_if.src                      tk
);
  logic [tspwm_pkg::PRE_W-1:0] pre_r;
  logic [tspwm_pkg::NCH-1:0]   s1_r;
  logic [tspwm_pkg::NCH-1:0]   s2_r;
  logic [tspwm_pkg::NCH-1:0]   s3_r;

  // ==========================================================
  // Divider and ext synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= tspwm_pkg::PRE_RST;
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
    end else begin
      pre_r <= pre_r + 3'h1;
      s1_r  <= ext_clk;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
    end
  end

  // ==========================================================
  // Tick select
  genvar g;
  generate
    for (g = 0; g < tspwm_pkg::NCH; g++) begin : g_ch
      wire [2:0] sel = cks[3*g +: 3];
      wire [1:0] eg  = edge_sel[2*g +: 2];
      wire rise = s2_r[g] & ~s3_r[g];
      wire fall = ~s2_r[g] & s3_r[g];
      wire ext_t = (eg == 2'h0) ? rise :
                   (eg == 2'h1) ? fall : (rise | fall);
      assign tk.tick[g] =
        (sel == tspwm_pkg::CKS_DIV1) ? 1'b1 :
        (sel == tspwm_pkg::CKS_DIV2) ? (pre_r[0] == 1'b1) :
        (sel == tspwm_pkg::CKS_DIV4) ? (pre_r[1:0] == 2'h3) :
        (sel == tspwm_pkg::CKS_DIV8) ? (pre_r == 3'h7) :
        (sel == tspwm_pkg::CKS_EXT)  ? ext_t : 1'b0;
    end
  endgenerate
endmodule

// ==== core/tspwm_top.sv ====
// Five-channel 16-bit timer: sync preset/clear, PWM, reset-synced PWM.
// Assumes software drives configuration ports from the same clock.
`timescale 1ns/1ns
module tspwm_top (
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire logic [tspwm_pkg::NCH-1:0]     START_REGISTER,
  input  wire logic [tspwm_pkg::NCH-1:0]     CHANNEL_SYNC_REGISTER,
  input  wire logic [tspwm_pkg::NCH-1:0]     PWM_MODE,
  input  wire logic [1:0]                    COMBINED_MODE_SELECT,
  input  wire logic [2*tspwm_pkg::NCH-1:0]   COUNTER_CLEAR_SELECT,
  input  wire logic [3*tspwm_pkg::NCH-1:0]   COUNT_CLOCK_SELECT,
  input  wire logic [2*tspwm_pkg::NCH-1:0]   EXT_EDGE_SELECT,
  input  wire logic [2*tspwm_pkg::NCH-1:0]   PIN_B_IO_SELECT,
  input  wire logic [tspwm_pkg::NCH-1:0]     EXT_COUNT_CLK,
  input  wire logic [tspwm_pkg::NCH-1:0]     CNT_WR,
  input  wire logic [tspwm_pkg::NCH-1:0]     GRA_WR,
  input  wire logic [tspwm_pkg::NCH-1:0]     GRB_WR,
  input  wire logic [tspwm_pkg::CW-1:0]      WR_DATA,
  output logic [tspwm_pkg::NCH*tspwm_pkg::CW-1:0] TIMER_COUNTER_VALUE,
  output logic [tspwm_pkg::NCH*tspwm_pkg::CW-1:0] GENERAL_REG_A,
  output logic [tspwm_pkg::NCH*tspwm_pkg::CW-1:0] GENERAL_REG_B,
  output logic [tspwm_pkg::NCH-1:0]          COMPARE_PIN_A,
  output logic [tspwm_pkg::NCH-1:0]          COMPARE_PIN_B,
  output logic                               INVERSE_OUTPUT_2,
  output logic                               INVERSE_OUTPUT_3,
  output logic                               RSPWM_ACTIVE
);
  localparam int N = tspwm_pkg::NCH;
  localparam int W = tspwm_pkg::CW;

  logic [W-1:0] cnt_r [N];
  logic [W-1:0] gra_r [N];
  logic [W-1:0] grb_r [N];
  logic [N-1:0] pa_r;
  logic [N-1:0] pb_r;
  logic [2:0]   rs_r;
  logic [W-1:0] cnt_nxt [N];

  tspwm_tick_if tk ();

  tspwm_prescale u_pre (
    .clk      (CLK),
    .rst_n    (RST_N),
    .cks      (COUNT_CLOCK_SELECT),
    .edge_sel (EXT_EDGE_SELECT),
    .ext_clk  (EXT_COUNT_CLK),
    .tk       (tk)
  );

  // ==========================================================
  // Mode decode
  wire rs_mode = (COMBINED_MODE_SELECT == tspwm_pkg::CMD_RSPWM);
  assign RSPWM_ACTIVE = rs_mode;

  // Count enable per channel: run bit and tick
  wire [N-1:0] cnt_en = START_REGISTER & tk.tick;

  // Compare source: ch4 compares against counter 3 in reset-synced mode
  function automatic logic [W-1:0] cmp_cnt(input int c, input logic rs,
                                           input logic [W-1:0] c3,
                                           input logic [W-1:0] cc);
    cmp_cnt = (rs && c == 4) ? c3 : cc;
  endfunction

  // ==========================================================
  // Compare match and clear decode
  logic [N-1:0] ma;
  logic [N-1:0] mb;
  logic [N-1:0] own_clr;
  logic [N-1:0] sync_clr_sel;
  logic [N-1:0] any_wr_sync;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_m
      wire [W-1:0] cv = cmp_cnt(g, rs_mode, cnt_r[3], cnt_r[g]);
      wire [1:0] cs = COUNTER_CLEAR_SELECT[2*g +: 2];
      wire en_cmp = (rs_mode && g == 4) ? cnt_en[3] : cnt_en[g];
      // Match fires on the tick that leaves the matching value
      assign ma[g] = en_cmp && (cv == gra_r[g]);
      assign mb[g] = en_cmp && (cv == grb_r[g]);
      // Counter 3 forced to clear on its A match in reset-synced mode
      assign own_clr[g] = (rs_mode && g == 3) ? ma[3] :
                          (cs == tspwm_pkg::CLR_A) ? ma[g] :
                          (cs == tspwm_pkg::CLR_B) ? mb[g] : 1'b0;
      assign sync_clr_sel[g] = CHANNEL_SYNC_REGISTER[g] &&
                               (cs == tspwm_pkg::CLR_SYNC);
      assign any_wr_sync[g] = CNT_WR[g] & CHANNEL_SYNC_REGISTER[g];
    end
  endgenerate

  // Clear broadcast only among synced channels
  wire sync_clr_ev = |(own_clr & CHANNEL_SYNC_REGISTER);
  wire sync_wr     = |any_wr_sync;

  // ==========================================================
  // Counter next value
  always_comb begin
    for (int c = 0; c < N; c++) begin
      cnt_nxt[c] = cnt_r[c];
      if (CNT_WR[c] || (sync_wr && CHANNEL_SYNC_REGISTER[c])) begin
        cnt_nxt[c] = WR_DATA;
      end else if (cnt_en[c]) begin
        if (own_clr[c] && !(rs_mode && c == 4)) begin
          cnt_nxt[c] = tspwm_pkg::CNT_RST;
        end else if (sync_clr_sel[c] && sync_clr_ev) begin
          cnt_nxt[c] = tspwm_pkg::CNT_RST;
        end else begin
          cnt_nxt[c] = cnt_r[c] + 16'h0001;
        end
      end else if (sync_clr_sel[c] && sync_clr_ev) begin
        cnt_nxt[c] = tspwm_pkg::CNT_RST;
      end
    end
  end

  // Clear of counter 3 in reset-synced mode
  wire rs_clr = rs_mode && ma[3];

  // ==========================================================
  // Registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int c = 0; c < N; c++) begin
        cnt_r[c] <= tspwm_pkg::CNT_RST;
        gra_r[c] <= tspwm_pkg::GR_RST;
        grb_r[c] <= tspwm_pkg::GR_RST;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        cnt_r[c] <= cnt_nxt[c];
        if (GRA_WR[c]) begin
          gra_r[c] <= WR_DATA;
        end
        if (GRB_WR[c]) begin
          grb_r[c] <= WR_DATA;
        end
      end
    end
  end

  // ==========================================================
  // Pin A and pin B waveforms
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pa_r <= '0;
      pb_r <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (PWM_MODE[c]) begin
          // Equal registers: both match at once, level held
          if (ma[c] && !mb[c]) begin
            pa_r[c] <= 1'b1;
          end else if (mb[c] && !ma[c]) begin
            pa_r[c] <= 1'b0;
          end
        end
        // Pin B follows its own select even in PWM mode
        if (mb[c]) begin
          case (PIN_B_IO_SELECT[2*c +: 2])
            tspwm_pkg::IOB_LO:  pb_r[c] <= 1'b0;
            tspwm_pkg::IOB_HI:  pb_r[c] <= 1'b1;
            tspwm_pkg::IOB_TOG: pb_r[c] <= ~pb_r[c];
            default:            pb_r[c] <= pb_r[c];
          endcase
        end
      end
    end
  end

  // Reset-synced turning points: ch3 B, ch4 A, ch4 B
  wire [2:0] rs_turn = {mb[4], ma[4], mb[3]};
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rs_r <= 3'h0;
    end else if (!rs_mode) begin
      rs_r <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        // Clear wins when turning point equals period: output stays set
        if (rs_clr) begin
          rs_r[k] <= 1'b1;
        end else if (rs_turn[k]) begin
          rs_r[k] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Output mux: six pins claimed in reset-synced mode
  always_comb begin
    COMPARE_PIN_A = pa_r;
    COMPARE_PIN_B = pb_r;
    INVERSE_OUTPUT_2 = 1'b0;
    INVERSE_OUTPUT_3 = 1'b0;
    if (rs_mode) begin
      COMPARE_PIN_A[3] = rs_r[0];
      COMPARE_PIN_B[3] = ~rs_r[0];
      COMPARE_PIN_A[4] = rs_r[1];
      INVERSE_OUTPUT_2 = ~rs_r[1];
      COMPARE_PIN_B[4] = rs_r[2];
      INVERSE_OUTPUT_3 = ~rs_r[2];
    end
  end

  generate
    for (g = 0; g < N; g++) begin : g_o
      assign TIMER_COUNTER_VALUE[W*g +: W] = cnt_r[g];
      assign GENERAL_REG_A[W*g +: W]       = gra_r[g];
      assign GENERAL_REG_B[W*g +: W]       = grb_r[g];
    end
  endgenerate
endmodule

// ==== test/tspwm_chk.sv ====
// Checker for the sync/PWM timer, bound to its top module.
// Assumes channels 0, 3 and 4 run from the undivided clock when checked.
`timescale 1ns/1ns
module tspwm_chk (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [4:0]  START_REGISTER,
  input wire logic [4:0]  CHANNEL_SYNC_REGISTER,
  input wire logic [4:0]  PWM_MODE,
  input wire logic [9:0]  COUNTER_CLEAR_SELECT,
  input wire logic [14:0] COUNT_CLOCK_SELECT,
  input wire logic [4:0]  CNT_WR,
  input wire logic [15:0] WR_DATA,
  input wire logic [79:0] TIMER_COUNTER_VALUE,
  input wire logic [79:0] GENERAL_REG_A,
  input wire logic [79:0] GENERAL_REG_B,
  input wire logic [4:0]  COMPARE_PIN_A,
  input wire logic [4:0]  COMPARE_PIN_B,
  input wire logic        INVERSE_OUTPUT_2,
  input wire logic        INVERSE_OUTPUT_3,
  input wire logic        RSPWM_ACTIVE
);
  // ==========================================================
  // Slices
  wire [15:0] c0 = TIMER_COUNTER_VALUE[15:0];
  wire [15:0] c1 = TIMER_COUNTER_VALUE[31:16];
  wire [15:0] c3 = TIMER_COUNTER_VALUE[63:48];
  wire [15:0] c4 = TIMER_COUNTER_VALUE[79:64];
  wire [15:0] a0 = GENERAL_REG_A[15:0];
  wire [15:0] b0 = GENERAL_REG_B[15:0];
  wire [15:0] a3 = GENERAL_REG_A[63:48];
  wire [15:0] b3 = GENERAL_REG_B[63:48];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Sequences: undivided tick only, so a match always moves on
  sequence s_run0;
    PWM_MODE[0] && START_REGISTER[0] && COUNT_CLOCK_SELECT[2:0] == 3'h0
    && CNT_WR == 5'h00;
  endsequence
  sequence s_run3;
    RSPWM_ACTIVE && START_REGISTER[3] && COUNT_CLOCK_SELECT[11:9] == 3'h0
    && CNT_WR == 5'h00;
  endsequence
  // ==========================================================
  // Assertions
  AST_RUN_HOLD: assert property (
    !START_REGISTER[0] && CNT_WR == 5'h00 && COUNTER_CLEAR_SELECT[1:0] != 2'h3
    |=> $stable(c0)) else $error("counter 0 moved while stopped");
  AST_SYNC_PRESET: assert property (
    CNT_WR[0] && CHANNEL_SYNC_REGISTER[1:0] == 2'h3
    |=> c1 == $past(WR_DATA)) else $error("sync preset missed channel 1");
  AST_PWM_SET: assert property (
    s_run0 ##0 (c0 == a0 && a0 != b0) |=> COMPARE_PIN_A[0])
    else $error("pin A0 not set on A match");
  AST_PWM_CLR: assert property (
    s_run0 ##0 (c0 == b0 && a0 != b0) |=> !COMPARE_PIN_A[0])
    else $error("pin A0 not cleared on B match");
  AST_PWM_EQ: assert property (
    s_run0 ##0 (c0 == a0 && a0 == b0) |=> $stable(COMPARE_PIN_A[0]))
    else $error("pin A0 moved on equal match");
  AST_PWM_PERIOD: assert property (
    s_run0 ##0 (c0 == b0 && COUNTER_CLEAR_SELECT[1:0] == 2'h2) |=> c0 == 16'h0)
    else $error("counter 0 not cleared on B match");
  AST_RS_PERIOD: assert property (
    s_run3 ##0 (c3 == a3) |=> c3 == 16'h0 && COMPARE_PIN_A[3])
    else $error("counter 3 period clear wrong");
  AST_RS_TURN: assert property (
    s_run3 ##0 (c3 == b3 && b3 != a3) |=> !COMPARE_PIN_A[3])
    else $error("pair 1 turning point missed");
  AST_RS_INV: assert property (
    RSPWM_ACTIVE && $past(RSPWM_ACTIVE) |-> COMPARE_PIN_B[3] != COMPARE_PIN_A[3]
    && INVERSE_OUTPUT_2 != COMPARE_PIN_A[4] && INVERSE_OUTPUT_3 != COMPARE_PIN_B[4])
    else $error("inverse pin not complementary");
  AST_RS_CNT4: assert property (
    RSPWM_ACTIVE && START_REGISTER[4] && COUNT_CLOCK_SELECT[14:12] == 3'h0
    && CNT_WR == 5'h00 && COUNTER_CLEAR_SELECT[9:8] != 2'h3
    |=> c4 == $past(c4) + 16'h0001) else $error("counter 4 not free running");
endmodule
bind tspwm_top tspwm_chk i_tspwm_chk (
  .CLK                   (CLK),
  .RST_N                 (RST_N),
  .START_REGISTER        (START_REGISTER),
  .CHANNEL_SYNC_REGISTER (CHANNEL_SYNC_REGISTER),
  .PWM_MODE              (PWM_MODE),
  .COUNTER_CLEAR_SELECT  (COUNTER_CLEAR_SELECT),
  .COUNT_CLOCK_SELECT    (COUNT_CLOCK_SELECT),
  .CNT_WR                (CNT_WR),
  .WR_DATA               (WR_DATA),
  .TIMER_COUNTER_VALUE   (TIMER_COUNTER_VALUE),
  .GENERAL_REG_A         (GENERAL_REG_A),
  .GENERAL_REG_B         (GENERAL_REG_B),
  .COMPARE_PIN_A         (COMPARE_PIN_A),
  .COMPARE_PIN_B         (COMPARE_PIN_B),
  .INVERSE_OUTPUT_2      (INVERSE_OUTPUT_2),
  .INVERSE_OUTPUT_3      (INVERSE_OUTPUT_3),
  .RSPWM_ACTIVE          (RSPWM_ACTIVE)
);

// ==== test/tspwm_load.sv ====
// Load on the channel 0 PWM pin: integrates cycles spent high.
// Assumes the bench clears it before each measurement.
`timescale 1ns/1ns
module tspwm_load (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        pin,
  output logic [15:0] hi_cnt
);
  always_ff @(posedge clk) hi_cnt <= clr ? 16'h0000 : hi_cnt + {15'h0, pin};
endmodule

// ==== test/timer_sync_and_pwm_modes_tb.sv ====
// Self-checking bench for the five-channel sync/PWM timer.
// Assumes only the top module's plain ports; ext clocks are driven here.
`timescale 1ns/1ns
module timer_sync_and_pwm_modes_tb;
  logic clk = 0, rst_n = 0, inv2, inv3, rsa, lclr = 1;
  logic [4:0] run = 0, sync = 0, pwm = 0, cw = 0, aw = 0, bw = 0, pa, pb;
  logic [1:0] cmd = 0;
  logic [9:0] clr = 0, iob = 10'h002, es = 0;
  logic [14:0] cks = 0;
  logic [4:0] ext = 0;
  logic [15:0] wd = 0, hi, d;
  logic [79:0] cnt, ga, gb;
  int fail_count = 0, checked = 0;
  tspwm_top i_tspwm_top (.CLK(clk), .RST_N(rst_n), .START_REGISTER(run),
    .CHANNEL_SYNC_REGISTER(sync), .PWM_MODE(pwm), .COMBINED_MODE_SELECT(cmd),
    .COUNTER_CLEAR_SELECT(clr), .COUNT_CLOCK_SELECT(cks),
    .EXT_EDGE_SELECT(es), .PIN_B_IO_SELECT(iob), .EXT_COUNT_CLK(ext),
    .CNT_WR(cw), .GRA_WR(aw), .GRB_WR(bw), .WR_DATA(wd),
    .TIMER_COUNTER_VALUE(cnt), .GENERAL_REG_A(ga), .GENERAL_REG_B(gb),
    .COMPARE_PIN_A(pa), .COMPARE_PIN_B(pb), .INVERSE_OUTPUT_2(inv2),
    .INVERSE_OUTPUT_3(inv3), .RSPWM_ACTIVE(rsa));
  tspwm_load i_tspwm_load (.clk(clk), .clr(lclr), .pin(pa[0]), .hi_cnt(hi));
  initial begin
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic do_rst();
    rst_n = 0; run = 0; pwm = 0; cmd = 0; sync = 0; clr = 0;
    cks = 0; es = 0; ext = 0;
    cyc(12);
    rst_n = 1;
  endtask
  // Kind 0 counter, 1 register A, 2 register B
  task automatic wr(int k, int c, logic [15:0] v);
    wd = v;
    if (k == 0) cw[c] = 1; else if (k == 1) aw[c] = 1; else bw[c] = 1;
    cyc(1);
    cw = 0; aw = 0; bw = 0;
  endtask
  // Channel 0 PWM: pin tracked from the counter value it leaves
  task automatic pwm_case(logic [15:0] a, b, logic [1:0] cs);
    logic [15:0] pc, hib;
    logic pe, pbe;
    do_rst();
    wr(1, 0, a); wr(2, 0, b); wr(0, 0, 16'h0000);
    cmp("gra0", a, ga[15:0]);
    cmp("grb0", b, gb[15:0]);
    clr[1:0] = cs; pwm[0] = 1; lclr = 1;
    iob[1:0] = iob[1:0] + 2'h1;
    cyc(1);
    lclr = 0; run[0] = 1; pe = 0; pbe = 0; hib = 0;
    repeat (60) begin
      hib += pe;
      pc = cnt[15:0];
      cyc(1);
      if (cnt[15:0] !== pc) begin
        if (a != b && pc == a) pe = 1;
        if (a != b && pc == b) pe = 0;
        if (pc == b) begin
          case (iob[1:0])
            2'h1: pbe = 0;
            2'h2: pbe = 1;
            2'h3: pbe = ~pbe;
            default: pbe = pbe;
          endcase
        end
        cmp("cnt0", ((cs == 2'h1 && pc == a) || (cs == 2'h2 && pc == b)) ?
            16'h0 : pc + 16'h1, cnt[15:0]);
      end
      cmp("pinA0", pe, pa[0]);
      cmp("pinB0", pbe, pb[0]);
    end
    cmp("load high", hib, hi);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] pc, p, t3, ta, tb;
    logic [2:0] e;
    logic known;
    void'($urandom(32'h27dd));
    do_rst();
    sync = 5'h07; d = 16'($urandom);
    wr(0, 1, d);
    cyc(2);
    cmp("cnt0", d, cnt[15:0]);
    cmp("cnt2", d, cnt[47:32]);
    cmp("cnt3", 16'h0, cnt[63:48]);
    cmp("cnt1 held", d, cnt[31:16]);
    do_rst();
    sync = 5'h03; clr = 10'h03e;
    wr(2, 0, 16'h0004); wr(0, 0, 16'h0000);
    run = 5'h07; pc = 16'h0000;
    repeat (30) begin
      cyc(1);
      pc = (pc == 16'h0004) ? 16'h0000 : pc + 16'h0001;
      cmp("cnt0 period", pc, cnt[15:0]);
      cmp("cnt1 sync cleared", pc, cnt[31:16]);
    end
    cmp("cnt2 free", 16'h001e, cnt[47:32]);
    // ==========================================================
    // Prescaled and external count clocks over eight whole divider cycles
    do_rst();
    cks = 15'h48d1; es = 10'h080;
    run = 5'h1f;
    for (int i = 0; i < 64; i++) begin
      if (i < 40 && i % 2 == 0) ext = ext ^ 5'h18;
      cyc(1);
    end
    run = 5'h00;
    cmp("cnt0 div2", 16'h0020, cnt[15:0]);
    cmp("cnt1 div4", 16'h0010, cnt[31:16]);
    cmp("cnt2 div8", 16'h0008, cnt[47:32]);
    cmp("cnt3 ext both", 16'h0014, cnt[63:48]);
    cmp("cnt4 ext rise", 16'h000a, cnt[79:64]);
    p = 16'(1 + $urandom % 8);
    t3 = 16'(p + 1 + $urandom % 8);
    pwm_case(p, t3, 2'h2);
    pwm_case(t3, p, 2'h1);
    pwm_case(16'h9, 16'h4, 2'h2);
    pwm_case(16'h3, 16'h9, 2'h1);
    pwm_case(16'h5, 16'h5, 2'h2);
    do_rst();
    p = 16'(6 + $urandom % 8);
    t3 = 16'($urandom % (p + 1));
    ta = 16'($urandom % (p + 1)); tb = p;
    wr(1, 3, p); wr(2, 3, t3); wr(1, 4, ta); wr(2, 4, tb);
    clr = 10'h040; cmd = 2'h3;
    wr(0, 3, 16'h0000);
    run = 5'h18; known = 0; e = 0;
    cmp("rs active", 1, rsa);
    cmp("grb4", tb, gb[79:64]);
    repeat (80) begin
      pc = cnt[63:48];
      cyc(1);
      if (cnt[63:48] !== pc) begin
        if (pc == p) begin
          known = 1; e = 3'h7;
        end else begin
          if (pc == t3) e[0] = 0;
          if (pc == ta) e[1] = 0;
          if (pc == tb) e[2] = 0;
        end
        cmp("cnt3", pc == p ? 16'h0 : pc + 16'h1, cnt[63:48]);
      end
      if (known) begin
        cmp("pair1", {e[0], ~e[0]}, {pa[3], pb[3]});
        cmp("pair2", {e[1], ~e[1]}, {pa[4], inv2});
        cmp("pair3", {e[2], ~e[2]}, {pb[4], inv3});
      end
    end
    cmp("rs period seen", 1, known);
    cmp("cnt4 free", 16'h0050, cnt[79:64]);
    summarize();
  end
endmodule
